// ---- ersw_pkg.sv ----
// ersw_pkg: constants for the error record select and window block.
// assumes a core-side system register port that names registers by encoding.
package ersw_pkg;
  // system register encodings, {op0,op1,crn,crm,op2} packed into 16 bits
  localparam logic [15:0] ENC_RECORD_COUNT = 16'hc298; // op1=0 crn=5 crm=3 op2=0
  localparam logic [15:0] ENC_SELECT = 16'hc298 + 16'h0001;
  localparam logic [15:0] ENC_FEATURE = 16'hc2a0;
  localparam logic [15:0] ENC_CONTROL = 16'hc2a1;
  localparam logic [15:0] ENC_STATUS = 16'hc2a2;
  localparam logic [15:0] ENC_ADDRESS = 16'hc2a3;
  localparam logic [15:0] ENC_MISC0 = 16'hc2a8;
  localparam logic [15:0] ENC_MISC1 = 16'hc2a9;
  // select register field layout and reset value
  localparam int SEL_MSB = 15;
  localparam logic [63:0] SEL_RESET = 64'h0;
  // window field codes presented to the record store
  typedef enum logic [2:0] {
    ERSW_WIN_FEATURE, ERSW_WIN_CONTROL, ERSW_WIN_STATUS,
    ERSW_WIN_ADDRESS, ERSW_WIN_MISC0, ERSW_WIN_MISC1
  } ersw_win_t;
  // outcome of one access
  typedef enum logic [2:0] {
    ERSW_OK, ERSW_UNDEF, ERSW_TRAP2, ERSW_TRAP3, ERSW_RAZWI
  } ersw_res_t;
endpackage

// ---- ersw_window.sv ----
// ersw_window: select register plus six window registers routed to a record store.
// assumes the core presents one access per cycle (req pulse) and the record store
// answers reads combinationally on rec_rdata in the same cycle.
//
// Summary of operation
// RULE_01 - select holds record index in bits 15:0
// RULE_02 - select bits 63:16 read zero, ignore writes
// RULE_03 - index n routes window to record n
// RULE_04 - each window forwards to selected record
// RULE_05 - out-of-range index may read back anything
// RULE_06 - out-of-range window access is read-zero/write-ignored
// RULE_07 - zero records: windows read-zero/write-ignored
// RULE_08 - zero records: select reads zero (reserved)
// RULE_09 - privilege level 0 access is undefined
// RULE_10 - level 2 trap bit traps non-secure level 1
// RULE_11 - level 3 trap bit traps levels 1, 2
// RULE_12 - feature window is read-only, reads only
// RULE_13 - select and RW windows read and writable
// RULE_14 - extension absent makes all accesses undefined
// RULE_15 - narrow-state alias shares select storage
// RULE_16 - record count field is highest index plus one
// RULE_17 - range check applied within the same access
module ersw_window #(
  parameter int NUM_RECORDS = 4, // implemented record count
  parameter bit EXT_PRESENT = 1'b1, // error record extension implemented
  parameter bit EL2_PRESENT = 1'b1,
  parameter bit EL3_PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic req, // one-cycle access request
  input wire logic wr, // 1 = sysreg_write_instr, 0 = sysreg_read_instr
  input wire logic narrow_alias, // access uses narrow_state_select_alias name
  input wire logic [15:0] enc, // system register encoding
  input wire logic [63:0] wdata,
  input wire logic [1:0] cur_level, // current privilege level
  input wire logic non_secure,
  input wire logic hyp_error_register_trap, // hypervisor_config trap bit
  input wire logic mon_error_register_trap, // secure_monitor_config trap bit
  input wire logic [63:0] rec_rdata, // data from the selected record field
  output logic rec_rd, // record field read strobe
  output logic rec_wr, // record field write strobe
  output logic [15:0] rec_index,
  output ersw_pkg::ersw_win_t rec_field,
  output logic [63:0] rec_wdata,
  output logic ack, // access completed, pulse
  output ersw_pkg::ersw_res_t result,
  output logic [63:0] rdata
);
  // reset release through two flops
  // assertion is immediate, release waits two edges so no flop sees a runt
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_n = rst_s2_q;

  // record count identity value
  // fixed at build time; a zero count turns every window into read-zero
  localparam logic [15:0] REC_COUNT = 16'(NUM_RECORDS); // RULE_16

  // decode: is this encoding one of ours, and which window
  function automatic logic is_window(input logic [15:0] e);
    is_window = (e == ersw_pkg::ENC_FEATURE) || (e == ersw_pkg::ENC_CONTROL) ||
                (e == ersw_pkg::ENC_STATUS) || (e == ersw_pkg::ENC_ADDRESS) ||
                (e == ersw_pkg::ENC_MISC0) || (e == ersw_pkg::ENC_MISC1);
  endfunction

  // field code for the record store; unknown encodings never strobe, so the
  // default branch only has to be harmless
  function automatic ersw_pkg::ersw_win_t win_of(input logic [15:0] e);
    case (e)
      ersw_pkg::ENC_FEATURE: win_of = ersw_pkg::ERSW_WIN_FEATURE;
      ersw_pkg::ENC_CONTROL: win_of = ersw_pkg::ERSW_WIN_CONTROL;
      ersw_pkg::ENC_STATUS: win_of = ersw_pkg::ERSW_WIN_STATUS;
      ersw_pkg::ENC_ADDRESS: win_of = ersw_pkg::ERSW_WIN_ADDRESS;
      ersw_pkg::ENC_MISC0: win_of = ersw_pkg::ERSW_WIN_MISC0;
      default: win_of = ersw_pkg::ERSW_WIN_MISC1;
    endcase
  endfunction

  // select storage; the narrow alias addresses the same flops
  logic [15:0] sel_q; // RULE_15

  // decode of the presented encoding, valid whenever enc is
  logic hit_sel; // select register named
  logic hit_id; // record count register read
  logic hit_win; // a window the access type may reach
  logic ours; // any register this block answers for
  // range check of the stored index against the record count
  logic in_range;
  // outcome of the access being presented this cycle
  ersw_pkg::ersw_res_t res_c;
  // read data before it is registered into rdata
  logic [63:0] rdata_c;

  // access classification, priority: undefined, level 2 trap, level 3 trap
  // a trap outranks the range check, so an out-of-range index still traps
  always_comb begin
    hit_sel = (enc == ersw_pkg::ENC_SELECT);
    hit_id = (enc == ersw_pkg::ENC_RECORD_COUNT) && !wr;
    hit_win = is_window(enc) && !(wr && enc == ersw_pkg::ENC_FEATURE); // RULE_12
    ours = hit_sel || hit_id || hit_win;
    in_range = (REC_COUNT != 16'h0000) && (sel_q < REC_COUNT); // RULE_17
    res_c = ersw_pkg::ERSW_OK;
    if (!EXT_PRESENT || !ours) begin
      res_c = ersw_pkg::ERSW_UNDEF; // RULE_14
    end else if (cur_level == 2'd0) begin
      res_c = ersw_pkg::ERSW_UNDEF; // RULE_09
    end else if (EL2_PRESENT && hyp_error_register_trap && non_secure &&
                 cur_level == 2'd1) begin
      res_c = ersw_pkg::ERSW_TRAP2; // RULE_10
    end else if (EL3_PRESENT && mon_error_register_trap &&
                 (cur_level == 2'd1 || cur_level == 2'd2)) begin
      res_c = ersw_pkg::ERSW_TRAP3; // RULE_11
    end else if (hit_win && !in_range) begin
      res_c = ersw_pkg::ERSW_RAZWI; // RULE_06 RULE_07
    end
  end

  // read data mux for the current access
  always_comb begin
    rdata_c = 64'h0;
    if (res_c == ersw_pkg::ERSW_OK) begin
      if (hit_sel) begin
        // reserved bits read zero; zero records reads zero
        rdata_c = (REC_COUNT == 16'h0000) ? 64'h0 : {48'h0, sel_q}; // RULE_02 RULE_08
      end else if (hit_id) begin
        rdata_c = {48'h0, REC_COUNT}; // RULE_16
      end else begin
        rdata_c = rec_rdata; // RULE_04
      end
    end
  end

  // qualified read and write requests; a low clock enable hides the request
  // from the store as well, so nothing moves while the block is frozen
  wire logic go = req && ce && !wr;
  wire logic gw = req && ce && wr;
  wire logic win_ok = hit_win && (res_c == ersw_pkg::ERSW_OK);

  // record store strobes: only in-range, permitted window accesses reach a record
  assign rec_rd = go && win_ok; // RULE_03 RULE_04
  assign rec_wr = gw && win_ok; // RULE_13
  assign rec_index = sel_q; // RULE_03
  assign rec_field = win_of(enc);
  assign rec_wdata = wdata;

  // select register write; narrow_alias only names it, storage is shared
  // an out-of-range index is kept so software reads back what it wrote
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= ersw_pkg::SEL_RESET[ersw_pkg::SEL_MSB:0];
    end else if (gw && hit_sel && res_c == ersw_pkg::ERSW_OK &&
                 REC_COUNT != 16'h0000) begin
      // any index stored, even out of range; reads it back as written
      sel_q <= wdata[ersw_pkg::SEL_MSB:0]; // RULE_01 RULE_05 RULE_13 RULE_15
    end
  end

  // registered answer, one cycle after the request
  // result and rdata hold until the next request, ack follows req on enabled cycles and holds while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      result <= ersw_pkg::ERSW_OK;
      rdata <= 64'h0;
    end else if (ce) begin
      ack <= req;
      if (req) begin
        result <= res_c;
        rdata <= wr ? 64'h0 : rdata_c;
      end
    end
  end

  // narrow alias is just a name; kept readable to avoid an unused input
  logic alias_seen_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) alias_seen_q <= 1'b0;
    else if (ce && req) alias_seen_q <= narrow_alias;
  end

  // checks
  // these sit beside the logic they guard and watch its inputs, decode signals and outputs;
  // the antecedents use the same decode signals as the logic so that a broken
  // priority chain shows up as a wrong result code rather than a silent pass
  a_level0_undef: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && req && cur_level == 2'd0) |=> (ack && result == ersw_pkg::ERSW_UNDEF)) // RULE_09
    else $error("level 0 access not undefined");
  a_trap_el2: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && req && EXT_PRESENT && ours && cur_level == 2'd1 && non_secure &&
     EL2_PRESENT && hyp_error_register_trap) |=> (result == ersw_pkg::ERSW_TRAP2)) // RULE_10
    else $error("missing level 2 trap");
  a_trap_el3: assert property (@(posedge clk) disable iff (!rst_n)
    (res_c == ersw_pkg::ERSW_TRAP3) |-> (cur_level != 2'd0 && mon_error_register_trap)) // RULE_11
    else $error("bad level 3 trap");
  a_sel_upper: assert property (@(posedge clk) disable iff (!rst_n)
    (ack && !$past(wr)) |-> (rdata[63:16] == 48'h0 || $past(hit_win))) // RULE_02
    else $error("select upper bits not zero");
  a_sel_write: assert property (@(posedge clk) disable iff (!rst_n)
    (gw && hit_sel && res_c == ersw_pkg::ERSW_OK && REC_COUNT != 16'h0000)
    |=> (sel_q == $past(wdata[15:0]))) // RULE_01
    else $error("select write lost");
  a_oor_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (req && hit_win && !in_range) |-> (!rec_rd && !rec_wr)) // RULE_06
    else $error("out of range reached a record");
  a_oor_raz: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && req && !wr && res_c == ersw_pkg::ERSW_RAZWI) |=> (rdata == 64'h0)) // RULE_07
    else $error("out of range read not zero");
  a_feature_ro: assert property (@(posedge clk) disable iff (!rst_n)
    (rec_wr) |-> (rec_field != ersw_pkg::ERSW_WIN_FEATURE)) // RULE_12
    else $error("feature window written");
  a_route_index: assert property (@(posedge clk) disable iff (!rst_n)
    (rec_rd || rec_wr) |-> (rec_index == sel_q && sel_q < REC_COUNT)) // RULE_03
    else $error("window routed to wrong record");
  a_ext_absent: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && req && !EXT_PRESENT) |=> (result == ersw_pkg::ERSW_UNDEF)) // RULE_14
    else $error("absent extension not undefined");

  // named steps of one access: the request taken, then its answer a cycle on
  sequence s_taken;
    ce && req;
  endsequence

  // the answer cycle; result and rdata are only meaningful here
  sequence s_answered;
    ack;
  endsequence

  // every taken request is answered exactly one cycle later
  // the core stalls on ack, so a lost answer would hang the pipeline
  a_ack_follows: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
    s_taken |=> s_answered)
    else $error("request not answered");

  // ack is a pulse: an idle enabled cycle always drops it
  a_ack_pulse: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
    (ce && !req) |=> !ack)
    else $error("ack held without a request");

  // a refused or faulting access never strobes the record store
  // this keeps undefined and trapped accesses free of side effects
  a_fault_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    (ce && req && res_c != ersw_pkg::ERSW_OK) |-> (!rec_rd && !rec_wr))
    else $error("refused access reached a record");

  // writes return no data, so a stale read value cannot leak out
  a_write_no_data: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    s_taken ##0 wr |=> (rdata == 64'h0))
    else $error("write returned data");

  // the identity value is the record count, upper bits zero
  a_id_value: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
    s_taken ##0 (hit_id && res_c == ersw_pkg::ERSW_OK) |=> (rdata == {48'h0, REC_COUNT}))
    else $error("record count read wrong");

  // a permitted select read returns the stored index with zero above it
  a_sel_readback: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    s_taken ##0 (!wr && hit_sel && res_c == ersw_pkg::ERSW_OK && REC_COUNT != 16'h0000)
    |=> (rdata == {48'h0, $past(sel_q)}))
    else $error("select read back wrong");

  // a refused select write leaves the index alone
  // traps must be restartable, so the faulting write may not land
  a_sel_refused: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    s_taken ##0 (wr && hit_sel && res_c != ersw_pkg::ERSW_OK) |=> $stable(sel_q))
    else $error("refused select write landed");

  // with no records the select register stays at zero for good
  a_zero_sel: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    (REC_COUNT == 16'h0000) |-> (sel_q == 16'h0000))
    else $error("select moved with no records");

  // a low clock enable freezes the index and the answer pulse
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    (!ce) |=> ($stable(sel_q) && $stable(ack)))
    else $error("state moved while disabled");

  // a write through the narrow alias lands in the same select flops
  a_alias_shared: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
    (ack && alias_seen_q && REC_COUNT != 16'h0000 &&
     $past(ce && req && wr && hit_sel && res_c == ersw_pkg::ERSW_OK))
    |-> (sel_q == $past(wdata[15:0])))
    else $error("alias write missed the select");

  // a permitted window read hands back what the store showed that cycle
  a_win_rdata: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    s_taken ##0 (!wr && win_ok) |=> (rdata == $past(rec_rdata)))
    else $error("window read data lost");

  // writing the read-only feature window is refused outright
  a_feature_wr: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
    s_taken ##0 (wr && enc == ersw_pkg::ENC_FEATURE && EXT_PRESENT && cur_level != 2'd0)
    |=> (result == ersw_pkg::ERSW_UNDEF))
    else $error("feature write not refused");

  // level 2 with the monitor trap bit set always goes to level 3
  // level 2 is never trapped to itself, so nothing outranks this here
  a_trap3_el2: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    s_taken ##0 (EXT_PRESENT && EL3_PRESENT && ours && cur_level == 2'd2 &&
                 mon_error_register_trap) |=> (result == ersw_pkg::ERSW_TRAP3))
    else $error("level 2 access not trapped");
endmodule

// ---- ersw_rec_model.sv ----
// ersw_rec_model: behavioural record store that sits behind the window block.
// assumes four records and read data returned combinationally in the strobe cycle.
module ersw_rec_model (
  input wire logic clk,
  input wire logic rec_rd,
  input wire logic rec_wr,
  input wire logic [15:0] rec_index,
  input wire ersw_pkg::ersw_win_t rec_field,
  input wire logic [63:0] rec_wdata,
  output logic [63:0] rec_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem_q [32]; // index times eight plus field code
  logic tog_q = 1'b0; // flips each cycle so an unstrobed bus never looks stable
  // plain storage; status write-clear behaviour is not modelled
  always_ff @(posedge clk) begin
    tog_q <= ~tog_q;
    if (rec_wr) begin
      mem_q[{rec_index[1:0], rec_field}] <= rec_wdata;
    end
  end
  // feature is fixed per record, so reads can tell records apart
  assign rec_rdata = !rec_rd ? {64{tog_q}} :
    (rec_field == ersw_pkg::ERSW_WIN_FEATURE) ? 64'hfe00 + 64'(rec_index) :
    mem_q[{rec_index[1:0], rec_field}];
endmodule

// ---- error_record_select_window_tb.sv ----
// error_record_select_window_tb: register-level tests of the select and window block.
// assumes four records, both higher levels present and the store model above.
module error_record_select_window_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, req = 1'b0, wr = 1'b0, ns = 1'b0, hyp = 1'b0, mon = 1'b0;
  logic ce = 1'b1, nal = 1'b0; // clock enable, narrow alias name in use
  logic [1:0] lvl = 2'h0; // current privilege level
  logic [15:0] enc = 16'h0;
  logic [63:0] wdata = 64'h0, rdata, rec_rdata, rec_wdata;
  logic rec_rd, rec_wr, ack;
  logic [15:0] rec_index;
  ersw_pkg::ersw_win_t rec_field;
  ersw_pkg::ersw_res_t result;
  int n_fail = 0, n_checks = 0, cyc = 0;
  logic [15:0] encs [5] = '{ersw_pkg::ENC_CONTROL, ersw_pkg::ENC_STATUS,
    ersw_pkg::ENC_ADDRESS, ersw_pkg::ENC_MISC0, ersw_pkg::ENC_MISC1};
  // clock enable and alias flag are driven by the last scenarios
  ersw_window #(.NUM_RECORDS(4)) dut_u (.clk(clk), .nrst(nrst), .ce(ce), .req(req),
    .wr(wr), .narrow_alias(nal), .enc(enc), .wdata(wdata), .cur_level(lvl),
    .non_secure(ns), .hyp_error_register_trap(hyp), .mon_error_register_trap(mon),
    .rec_rdata(rec_rdata), .rec_rd(rec_rd), .rec_wr(rec_wr), .rec_index(rec_index),
    .rec_field(rec_field), .rec_wdata(rec_wdata), .ack(ack), .result(result), .rdata(rdata));
  ersw_rec_model rec_u (.clk(clk), .rec_rd(rec_rd), .rec_wr(rec_wr), .rec_index(rec_index),
    .rec_field(rec_field), .rec_wdata(rec_wdata), .rec_rdata(rec_rdata));
  initial begin
    forever #10 clk = ~clk;
  end
  // distinct word per record and window
  function automatic logic [63:0] pat(input int r, input int w);
    return {48'hc0de_0000_0000, r[7:0], w[7:0]};
  endfunction
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one access: t is {non_secure, monitor trap, hypervisor trap}
  task automatic acc(input logic w, input logic [15:0] e, input logic [63:0] d,
    input logic [1:0] lv, input logic [2:0] t, input ersw_pkg::ersw_res_t xr,
    input logic [63:0] xd);
    logic win;
    win = (e != ersw_pkg::ENC_SELECT) && (e != ersw_pkg::ENC_RECORD_COUNT);
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    enc <= e;
    wdata <= d;
    lvl <= lv;
    {ns, mon, hyp} <= t;
    #5;
    // refused or out-of-range accesses must not touch the store
    chk("strobe", {62'h0, rec_rd, rec_wr},
      (xr == ersw_pkg::ERSW_OK && win) ? {62'h0, !w, w} : 64'h0);
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk("ack", {63'h0, ack}, 64'h1);
    chk("result", {61'h0, result}, {61'h0, xr});
    chk("rdata", rdata, xd);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard: the whole sequence needs under two hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    acc(0, ersw_pkg::ENC_SELECT, 0, 1, 3'b100, ersw_pkg::ERSW_OK, 0);
    acc(1, ersw_pkg::ENC_SELECT, 64'hffff_ffff_ffff_0003, 1, 3'b100, ersw_pkg::ERSW_OK, 0);
    acc(0, ersw_pkg::ENC_SELECT, 0, 1, 3'b100, ersw_pkg::ERSW_OK, 64'h3);
    for (int r = 0; r < 4; r++) begin
      acc(1, ersw_pkg::ENC_SELECT, r, 1, 3'b100, ersw_pkg::ERSW_OK, 0);
      for (int w = 0; w < 5; w++) acc(1, encs[w], pat(r, w), 1, 3'b100, ersw_pkg::ERSW_OK, 0);
    end
    for (int r = 0; r < 4; r++) begin
      acc(1, ersw_pkg::ENC_SELECT, r, 1, 3'b100, ersw_pkg::ERSW_OK, 0);
      acc(0, ersw_pkg::ENC_FEATURE, 0, 1, 3'b100, ersw_pkg::ERSW_OK, 64'hfe00 + r);
      for (int w = 0; w < 5; w++) acc(0, encs[w], 0, 1, 3'b100, ersw_pkg::ERSW_OK, pat(r, w));
    end
    acc(0, ersw_pkg::ENC_RECORD_COUNT, 0, 1, 3'b100, ersw_pkg::ERSW_OK, 64'h4);
    acc(1, ersw_pkg::ENC_FEATURE, 64'h1, 1, 3'b100, ersw_pkg::ERSW_UNDEF, 0);
    acc(0, ersw_pkg::ENC_CONTROL, 0, 0, 3'b100, ersw_pkg::ERSW_UNDEF, 0);
    acc(1, ersw_pkg::ENC_SELECT, 64'h1, 0, 3'b100, ersw_pkg::ERSW_UNDEF, 0);
    acc(0, ersw_pkg::ENC_MISC0, 0, 1, 3'b101, ersw_pkg::ERSW_TRAP2, 0);
    acc(0, ersw_pkg::ENC_MISC0, 0, 1, 3'b001, ersw_pkg::ERSW_OK, pat(3, 3));
    acc(0, ersw_pkg::ENC_SELECT, 0, 2, 3'b101, ersw_pkg::ERSW_OK, 64'h3);
    acc(0, ersw_pkg::ENC_STATUS, 0, 1, 3'b111, ersw_pkg::ERSW_TRAP2, 0);
    acc(0, ersw_pkg::ENC_ADDRESS, 0, 2, 3'b010, ersw_pkg::ERSW_TRAP3, 0);
    acc(1, ersw_pkg::ENC_SELECT, 64'h5, 1, 3'b110, ersw_pkg::ERSW_TRAP3, 0);
    acc(1, ersw_pkg::ENC_SELECT, 64'h4, 1, 3'b100, ersw_pkg::ERSW_OK, 0);
    acc(0, ersw_pkg::ENC_SELECT, 0, 1, 3'b100, ersw_pkg::ERSW_OK, 64'h4);
    acc(1, ersw_pkg::ENC_CONTROL, 64'hbad, 1, 3'b100, ersw_pkg::ERSW_RAZWI, 0);
    acc(0, ersw_pkg::ENC_CONTROL, 0, 1, 3'b100, ersw_pkg::ERSW_RAZWI, 0);
    acc(1, ersw_pkg::ENC_SELECT, 64'h0, 1, 3'b100, ersw_pkg::ERSW_OK, 0);
    acc(0, ersw_pkg::ENC_CONTROL, 0, 1, 3'b100, ersw_pkg::ERSW_OK, pat(0, 0));
    // select written through the narrow alias name, then a write with ce low
    @(posedge clk);
    nal <= 1'b1;
    acc(1, ersw_pkg::ENC_SELECT, 64'h2, 1, 3'b100, ersw_pkg::ERSW_OK, 0);
    @(posedge clk);
    nal <= 1'b0;
    ce <= 1'b0;
    req <= 1'b1;
    wr <= 1'b1;
    enc <= ersw_pkg::ENC_SELECT;
    wdata <= 64'h1;
    @(posedge clk);
    req <= 1'b0;
    ce <= 1'b1;
    #1;
    chk("frozen ack", {63'h0, ack}, 64'h0);
    acc(0, ersw_pkg::ENC_SELECT, 0, 1, 3'b100, ersw_pkg::ERSW_OK, 64'h2);
    report_and_stop();
  end
endmodule
